// ===== hw/fcs_defines.svh
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
// Register indices; byte address is four times the index
`define FCS_IDX_CLKDIV   4'h0
`define FCS_IDX_SEC      4'h1
`define FCS_IDX_CFG      4'h2
`define FCS_IDX_ERRCFG   4'h3
`define FCS_IDX_STAT     4'h4
`define FCS_IDX_ERRSTAT  4'h5
`define FCS_IDX_PIDX     4'h6
`define FCS_IDX_PDATA    4'h7
`define FCS_IDX_CMD      4'h8
`define FCS_IDX_PROT     4'h9
`define FCS_IDX_ECCADR   4'ha
`define FCS_NUM_REGS     4'hb
// Status register bits
`define FCS_ST_COMMAND_COMPLETE_FLAG      7
`define FCS_ST_ACCESS_ERROR_FLAG    5
`define FCS_ST_PROTECTION_VIOLATION_FLAG    4
`define FCS_ST_MG1       1
`define FCS_ST_MG0       0
// Error status / error config bits
`define FCS_ER_DFD       1
`define FCS_ER_SFD       0
`define FCS_ER_EMU_LSB   2
// Protect register: bits 2..0 program region, 4..3 data region
`define FCS_PROT_ALL     5'h1f
// Security byte
`define FCS_SEC_ADDR     23'h7fff0f
`define FCS_SEC_ALLSET   8'hff
`define FCS_BACKDOOR_ENABLE_FIELD_ON     2'h2
`define FCS_SEC_FORCE    2'h2
`define FCS_CFG_COMMAND_COMPLETE_IRQ_ENABLE     7
// Command codes
`define FCS_C_RDONCE     8'h04
`define FCS_C_ERSALL     8'h08
`define FCS_C_UNSEC      8'h0b
`define FCS_C_UMARGIN    8'h0d
`define FCS_C_FMARGIN    8'h0e
`define FCS_C_FULLPART   8'h0f
`define FCS_C_ERSVFY     8'h10
`define FCS_C_PGM        8'h11
`define FCS_C_ERSSEC     8'h12
`define FCS_C_EEEON      8'h13
`define FCS_C_EEEOFF     8'h14
`define FCS_C_EEEQ       8'h15
`define FCS_C_PART       8'h20
// Read Once parameter indices and limit
`define FCS_PI_CMD       3'h0
`define FCS_PI_PHRASE    3'h1
`define FCS_PI_W0        3'h2
`define FCS_RO_MAXIDX    16'h0007
`endif

// ===== hw/fcs_pkg.sv
package fcs_pkg;
    typedef enum logic [2:0] {
        ST_BOOT, ST_BOOT_WAIT, ST_IDLE, ST_RDONCE, ST_ALGO
    } fcs_state_t;
    typedef struct packed {
        logic        req;
        logic [22:0] addr;
    } fcs_nvm_req_t;
    typedef struct packed {
        logic        ack;
        logic [63:0] data;
        logic        err;
        logic        dbl;
    } fcs_nvm_rsp_t;
    typedef struct packed {
        logic        strobe;
        logic        pblock0;
        logic        dflash;
        logic [22:0] addr;
    } fcs_rd_t;
endpackage

// ===== hw/fcs_top.sv
// Function
// - Security register read-only at index one
// - Reset loads security byte from configuration
// - Double fault at load sets all bits
// - Backdoor enabled only when field is 10
// - Backdoor unsecure forces lock bits 10
// - Erase all needs every protect bit set
// - Unsecure erases all then verifies
// - User margin; field margin special only
// - Full partition erases; partition does not
// - Erase verify, program, sector erase codes
// - Emulation enable, disable, query codes
// - Bad code, or program/erase with no divider, sets error
// - Data flash read during algorithm, or any read in erase all/unsecure, flags both faults if neither is set
// - Read once uses phrase index parameters
// - Clearing complete launches read, sets after
// - Block zero reads invalid during read
// - Read once launch errors set access error
// - Verify status bits track read errors
// - Command irq is flag and enable
// - Error irq from seven gated flags
//
// The APB slave port was decided locally.
`include "fcs_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module fcs_top
    import fcs_pkg::*;
#(
    parameter logic [22:0] RO_BASE = 23'h400000
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    output fcs_nvm_req_t      nvm_out,
    input  wire fcs_nvm_rsp_t nvm_in,
    input  wire fcs_rd_t      rd_in,
    output logic              rd_invalid,
    input  wire logic         special_mode,
    input  wire logic         load_field_active,
    input  wire logic         backdoor_unlock,
    input  wire logic [4:0]   emu_err_set,
    input  wire logic         single_fault_set,
    output logic              algo_start,
    output logic [7:0]        algo_cmd,
    input  wire logic         algo_done,
    output logic              backdoor_enabled,
    output logic              cmd_irq,
    output logic              err_irq
);
    // Misaligned base would split the phrase fetch
    if (RO_BASE[2:0] != 3'h0) begin : g_bad_base
        $error("Read once base must be phrase aligned");
    end

    function automatic logic cmd_known(input logic [7:0] c);
        unique case (c)
            `FCS_C_RDONCE, `FCS_C_ERSALL, `FCS_C_UNSEC,
            `FCS_C_UMARGIN, `FCS_C_FMARGIN, `FCS_C_FULLPART,
            `FCS_C_ERSVFY, `FCS_C_PGM, `FCS_C_ERSSEC,
            `FCS_C_EEEON, `FCS_C_EEEOFF, `FCS_C_EEEQ,
            `FCS_C_PART: cmd_known = 1'b1;
            default:     cmd_known = 1'b0;
        endcase
    endfunction

    function automatic logic cmd_pe(input logic [7:0] c);
        unique case (c)
            `FCS_C_ERSALL, `FCS_C_UNSEC, `FCS_C_FULLPART,
            `FCS_C_PGM, `FCS_C_ERSSEC,
            `FCS_C_PART: cmd_pe = 1'b1;
            default:     cmd_pe = 1'b0;
        endcase
    endfunction

    fcs_state_t  state;
    logic [7:0]  clkdiv;
    logic        div_set;
    logic [7:0]  sec;
    logic        command_complete_flag;
    logic        access_error_flag;
    logic        protection_violation_flag;
    logic [1:0]  mgstat;
    logic        command_complete_irq_enable;
    logic [6:0]  err_en;
    logic [6:0]  err_flags;
    logic [2:0]  pidx;
    logic [15:0] params [6];
    logic [4:0]  prot;
    logic [22:0] ecc_addr;

    logic        acc;
    logic        wr;
    logic        rd;
    logic [3:0]  ridx;
    logic        mapped;
    assign acc    = psel & penable & pready;
    assign wr     = acc & pwrite;
    assign ridx   = paddr[5:2];
    assign mapped = (paddr[1:0] == 2'h0) && (paddr[31:6] == 26'h0)
                    && (ridx < `FCS_NUM_REGS);
    assign rd     = psel & penable & ~pready;

    // Launch by writing one to the complete flag while idle
    logic launch;
    logic [7:0] lcmd;
    logic lbad;
    logic ro_bad;
    assign launch = wr && mapped && ridx == `FCS_IDX_STAT
                    && pwdata[`FCS_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag
                    && state == ST_IDLE;
    assign lcmd   = params[`FCS_PI_CMD][15:8];
    assign ro_bad = pidx != `FCS_PI_PHRASE || load_field_active
                    || params[`FCS_PI_PHRASE] > `FCS_RO_MAXIDX;
    assign lbad   = !cmd_known(lcmd)
                    || (cmd_pe(lcmd) && !div_set)
                    || (lcmd == `FCS_C_FMARGIN && !special_mode)
                    || (lcmd == `FCS_C_RDONCE && ro_bad)
                    || access_error_flag || protection_violation_flag;
    logic lprot;
    assign lprot  = lcmd == `FCS_C_ERSALL && prot != `FCS_PROT_ALL;

    // Bus answer: one wait state, registered data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd;
            pslverr <= rd & ~mapped;
            if (rd && !pwrite && mapped) begin
                unique case (ridx)
                    `FCS_IDX_CLKDIV:  prdata <= {24'h0, clkdiv};
                    `FCS_IDX_SEC:     prdata <= {24'h0, sec};
                    `FCS_IDX_CFG:     prdata <= {24'h0, command_complete_irq_enable, 7'h0};
                    `FCS_IDX_ERRCFG:  prdata <= {25'h0, err_en};
                    `FCS_IDX_STAT:    prdata <= {24'h0, command_complete_flag, 1'b0,
                                         access_error_flag, protection_violation_flag, 2'h0, mgstat};
                    `FCS_IDX_ERRSTAT: prdata <= {25'h0, err_flags};
                    `FCS_IDX_PIDX:    prdata <= {29'h0, pidx};
                    `FCS_IDX_PDATA:   prdata <= (pidx < 3'h6) ?
                                         {16'h0, params[pidx]} : 32'h0;
                    `FCS_IDX_CMD:     prdata <= {24'h0, algo_cmd};
                    `FCS_IDX_PROT:    prdata <= {27'h0, prot};
                    `FCS_IDX_ECCADR:  prdata <= {9'h0, ecc_addr};
                    default:          prdata <= 32'h0;
                endcase
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // Plain software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clkdiv <= 8'h0;
            div_set <= 1'b0;
            command_complete_irq_enable   <= 1'b0;
            err_en <= 7'h0;
            prot   <= 5'h0;
            pidx   <= 3'h0;
        end else if (wr && mapped) begin
            unique case (ridx)
                `FCS_IDX_CLKDIV: begin
                    clkdiv  <= pwdata[7:0];
                    div_set <= 1'b1;
                end
                `FCS_IDX_CFG:    command_complete_irq_enable   <= pwdata[`FCS_CFG_COMMAND_COMPLETE_IRQ_ENABLE];
                `FCS_IDX_ERRCFG: err_en <= pwdata[6:0];
                `FCS_IDX_PROT:   prot   <= pwdata[4:0];
                `FCS_IDX_PIDX: begin
                    if (command_complete_flag && state == ST_IDLE)
                        pidx <= pwdata[2:0];
                end
                default: ;
            endcase
        end
    end

    // Command sequencer and nonvolatile read port
    logic [63:0] d;
    assign d = nvm_in.data;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_BOOT;
            nvm_out    <= '0;
            sec        <= 8'h0;
            algo_start <= 1'b0;
            algo_cmd   <= 8'h0;
            for (int i = 0; i < 6; i++)
                params[i] <= 16'h0;
        end else begin
            algo_start <= 1'b0;
            if (wr && mapped && ridx == `FCS_IDX_PDATA && command_complete_flag
                && state == ST_IDLE && pidx < 3'h6)
                params[pidx] <= pwdata[15:0];
            if (backdoor_unlock)
                sec[1:0] <= `FCS_SEC_FORCE;
            unique case (state)
                ST_BOOT: begin
                    nvm_out.req  <= 1'b1;
                    nvm_out.addr <= `FCS_SEC_ADDR;
                    state        <= ST_BOOT_WAIT;
                end
                ST_BOOT_WAIT: begin
                    if (nvm_in.ack) begin
                        nvm_out.req <= 1'b0;
                        // Phrase is big endian; byte 7 is low
                        sec <= nvm_in.dbl ? `FCS_SEC_ALLSET
                                          : d[7:0];
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (launch && !lbad && !lprot) begin
                        algo_cmd <= lcmd;
                        if (lcmd == `FCS_C_RDONCE) begin
                            nvm_out.req  <= 1'b1;
                            nvm_out.addr <= RO_BASE +
                                {params[`FCS_PI_PHRASE][2:0], 3'h0};
                            state <= ST_RDONCE;
                        end else begin
                            // Erase-all, unsecure, margins, partition,
                            // verify, program, sector erase, emulation
                            algo_start <= 1'b1;
                            state      <= ST_ALGO;
                        end
                    end
                end
                ST_RDONCE: begin
                    if (nvm_in.ack) begin
                        nvm_out.req <= 1'b0;
                        for (int w = 0; w < 4; w++)
                            params[w + 2] <= d[63 - 16*w -: 16];
                        state <= ST_IDLE;
                    end
                end
                ST_ALGO: begin
                    if (algo_done)
                        state <= ST_IDLE;
                end
                default: state <= ST_BOOT;
            endcase
        end
    end

    // Status flags; hardware set wins over software clear
    logic clr_stat;
    logic done_now;
    assign clr_stat = wr && mapped && ridx == `FCS_IDX_STAT;
    assign done_now = (state == ST_BOOT_WAIT && nvm_in.ack)
                      || (state == ST_RDONCE && nvm_in.ack)
                      || (state == ST_ALGO && algo_done);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_complete_flag   <= 1'b0;
            access_error_flag <= 1'b0;
            protection_violation_flag <= 1'b0;
            mgstat <= 2'h0;
        end else begin
            if (done_now)
                command_complete_flag <= 1'b1;
            else if (launch && !lbad && !lprot)
                command_complete_flag <= 1'b0;
            if (launch && lbad)
                access_error_flag <= 1'b1;
            else if (clr_stat && pwdata[`FCS_ST_ACCESS_ERROR_FLAG])
                access_error_flag <= 1'b0;
            if (launch && !lbad && lprot)
                protection_violation_flag <= 1'b1;
            else if (clr_stat && pwdata[`FCS_ST_PROTECTION_VIOLATION_FLAG])
                protection_violation_flag <= 1'b0;
            if (launch && !lbad && !lprot)
                mgstat <= 2'h0;
            else if (state == ST_RDONCE && nvm_in.ack)
                mgstat <= {nvm_in.err | nvm_in.dbl, nvm_in.dbl};
        end
    end

    // Invalid reads while an algorithm owns the block
    logic hit;
    logic all_blk;
    assign all_blk = algo_cmd == `FCS_C_ERSALL
                     || algo_cmd == `FCS_C_UNSEC;
    assign hit = rd_in.strobe
                 && ((state == ST_ALGO && (all_blk || rd_in.dflash))
                 || (state == ST_RDONCE && rd_in.pblock0));
    logic [6:0] err_clr;
    assign err_clr = (wr && mapped && ridx == `FCS_IDX_ERRSTAT) ?
                     pwdata[6:0] : 7'h0;
    logic first_bad;
    assign first_bad = hit && !err_flags[`FCS_ER_SFD]
                       && !err_flags[`FCS_ER_DFD];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_flags  <= 7'h0;
            ecc_addr   <= 23'h0;
            rd_invalid <= 1'b0;
        end else begin
            rd_invalid <= hit;
            err_flags[6:`FCS_ER_EMU_LSB] <=
                (err_flags[6:`FCS_ER_EMU_LSB] & ~err_clr[6:2])
                | emu_err_set;
            err_flags[`FCS_ER_DFD] <= (err_flags[`FCS_ER_DFD]
                & ~err_clr[`FCS_ER_DFD]) | first_bad;
            err_flags[`FCS_ER_SFD] <= (err_flags[`FCS_ER_SFD]
                & ~err_clr[`FCS_ER_SFD]) | first_bad
                | single_fault_set;
            if (first_bad)
                ecc_addr <= rd_in.addr;
        end
    end

    // Level interrupt requests and backdoor status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_irq          <= 1'b0;
            err_irq          <= 1'b0;
            backdoor_enabled <= 1'b0;
        end else begin
            cmd_irq <= command_complete_flag & command_complete_irq_enable;
            err_irq <= |(err_flags & err_en);
            backdoor_enabled <= sec[7:6] == `FCS_BACKDOOR_ENABLE_FIELD_ON;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_sec_readonly: assert property (
        wr && ridx == `FCS_IDX_SEC && state == ST_IDLE && !backdoor_unlock
        |=> $stable(sec))
        else $error("Security register changed by a write");
    chk_sec_dbl: assert property (
        state == ST_BOOT_WAIT && nvm_in.ack && nvm_in.dbl
        |=> sec == `FCS_SEC_ALLSET)
        else $error("Double fault did not set security bits");
    chk_backdoor_enable_field: assert property (
        ##1 backdoor_enabled == ($past(sec[7:6]) == `FCS_BACKDOOR_ENABLE_FIELD_ON))
        else $error("Backdoor enable mismatch");
    chk_backdoor_force: assert property (
        backdoor_unlock |=> sec[1:0] == `FCS_SEC_FORCE)
        else $error("Lock bits not forced on unlock");
    chk_ersall_prot: assert property (
        launch && lcmd == `FCS_C_ERSALL && !lbad && prot != `FCS_PROT_ALL
        |=> protection_violation_flag && !algo_start && state == ST_IDLE)
        else $error("Erase all ran with protection on");
    chk_bad_cmd: assert property (
        launch && !cmd_known(lcmd) |=> access_error_flag && command_complete_flag)
        else $error("Invalid code not refused");
    chk_inv_read: assert property (
        first_bad |=> err_flags[`FCS_ER_SFD] && err_flags[`FCS_ER_DFD]
        && ecc_addr == $past(rd_in.addr) && rd_invalid)
        else $error("Invalid read not captured");
    chk_ro_done: assert property (
        state == ST_RDONCE && nvm_in.ack
        |=> command_complete_flag && state == ST_IDLE ##1 !nvm_out.req)
        else $error("Read once did not complete");
    chk_ro_idx: assert property (
        launch && lcmd == `FCS_C_RDONCE && pidx != `FCS_PI_PHRASE
        |=> access_error_flag && state == ST_IDLE)
        else $error("Bad index not refused");
    chk_err_irq: assert property (
        (err_flags & err_en) != 7'h0 [*2] |-> err_irq)
        else $error("Error irq not asserted");
endmodule
`default_nettype wire

// ===== verif/fcs_top_tb_top.sv
`include "fcs_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module fcs_top_tb_top;
    import fcs_pkg::*;
    localparam logic [22:0] RO_BASE = 23'h400100;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic         rd_invalid, special_mode, load_field_active, algo_done;
    logic         backdoor_unlock, single_fault_set, algo_start, serr;
    logic         backdoor_enabled, cmd_irq, err_irq, e, db;
    logic [31:0]  paddr, pwdata, prdata, rdv;
    logic [4:0]   emu_err_set;
    logic [7:0]   algo_cmd, sec, c;
    logic [63:0]  d;
    logic [22:0]  a;
    fcs_nvm_req_t nvm_out;
    fcs_nvm_rsp_t nvm_in;
    fcs_rd_t      rd_in;
    int           n_fail, n_checks, n_start, n_inv, s, p;
    logic [7:0]   codes [12] = '{`FCS_C_ERSALL, `FCS_C_UNSEC, `FCS_C_UMARGIN,
        `FCS_C_FMARGIN, `FCS_C_FULLPART, `FCS_C_ERSVFY, `FCS_C_PGM,
        `FCS_C_ERSSEC, `FCS_C_EEEON, `FCS_C_EEEOFF, `FCS_C_EEEQ, `FCS_C_PART};

    fcs_top #(.RO_BASE(RO_BASE)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .nvm_out(nvm_out), .nvm_in(nvm_in), .rd_in(rd_in),
        .rd_invalid(rd_invalid), .special_mode(special_mode),
        .load_field_active(load_field_active),
        .backdoor_unlock(backdoor_unlock), .emu_err_set(emu_err_set),
        .single_fault_set(single_fault_set), .algo_start(algo_start),
        .algo_cmd(algo_cmd), .algo_done(algo_done),
        .backdoor_enabled(backdoor_enabled), .cmd_irq(cmd_irq),
        .err_irq(err_irq));

    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        if (algo_start === 1'b1) n_start <= n_start + 1;
        if (rd_invalid === 1'b1) n_inv <= n_inv + 1;
    end

    function automatic logic valid_code(input logic [7:0] k);
        return k inside {codes, `FCS_C_RDONCE};
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Entered just after a rising edge; one idle edge at the end
    task apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {26'h0, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        rdv = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [3:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task rdc(input logic [3:0] idx, input logic [31:0] mk,
             input logic [31:0] exp, input string m);
        apb(1'b0, idx, 32'h0);
        chk(rdv & mk, exp, m);
    endtask

    // Registered levels lag their cause; look mid-cycle, realign after
    task lvl(input int w, input logic exp, input string m);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk((w == 0) ? cmd_irq : (w == 1) ? err_irq : backdoor_enabled,
            exp, m);
        @(posedge pclk);
    endtask

    task nvm_ans(input logic [63:0] dd, input logic ee, input logic bb,
                 input logic [22:0] ea);
        int n;
        n = 0;
        while (nvm_out.req !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk({9'h0, nvm_out.addr}, {9'h0, ea}, "fetch address");
        nvm_in <= '{ack: 1'b1, data: dd, err: ee, dbl: bb};
        @(posedge pclk);
        nvm_in <= '{ack: 1'b0, data: ~dd, err: 1'b0, dbl: 1'b0};
        repeat (2) @(posedge pclk);
    endtask

    task boot(input logic [7:0] sb, input logic bb);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        nvm_ans({{7{8'(~sb)}}, sb}, 1'b0, bb, `FCS_SEC_ADDR);
    endtask

    task launch(input logic [7:0] k);
        wr(`FCS_IDX_PIDX, 32'h0);
        wr(`FCS_IDX_PDATA, {16'h0, k, 8'h00});
        wr(`FCS_IDX_STAT, 32'h80);
    endtask

    task ro(input logic [15:0] ph, input logic [2:0] li);
        wr(`FCS_IDX_PIDX, 32'h0);
        wr(`FCS_IDX_PDATA, 32'h0400);
        wr(`FCS_IDX_PIDX, 32'h1);
        wr(`FCS_IDX_PDATA, {16'h0, ph});
        wr(`FCS_IDX_PIDX, {29'h0, li});
        wr(`FCS_IDX_STAT, 32'h80);
    endtask

    task acc_err(input logic [31:0] exp, input string m);
        rdc(`FCS_IDX_STAT, 32'hb0, exp, m);
        wr(`FCS_IDX_STAT, 32'h30);
    endtask

    task rdpulse(input logic pb0, input logic df, input logic [22:0] ad);
        rd_in <= '{strobe: 1'b1, pblock0: pb0, dflash: df, addr: ad};
        @(posedge pclk);
        rd_in <= '{strobe: 1'b0, pblock0: 1'b0, dflash: 1'b0, addr: ~ad};
        repeat (2) @(posedge pclk);
    endtask

    task done_pulse;
        algo_done <= 1'b1;
        @(posedge pclk);
        algo_done <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, algo_done} = '0;
        {special_mode, load_field_active, backdoor_unlock} = '0;
        {single_fault_set, emu_err_set, paddr, pwdata} = '0;
        {n_fail, n_checks, n_start, n_inv} = '0;
        nvm_in = '0;
        rd_in = '0;
        void'($urandom(32415));
        for (int k = 0; k < 4; k++) begin
            sec = {k[1:0], 4'hf, 2'($urandom)};
            boot(sec, 1'b0);
            rdc(`FCS_IDX_SEC, 32'hff, {24'h0, sec}, "security load");
            lvl(2, sec[7:6] == `FCS_BACKDOOR_ENABLE_FIELD_ON, "backdoor enable");
        end
        wr(`FCS_IDX_SEC, {24'h0, ~sec});
        rdc(`FCS_IDX_SEC, 32'hff, {24'h0, sec}, "security write");
        backdoor_unlock <= 1'b1;
        @(posedge pclk);
        backdoor_unlock <= 1'b0;
        @(posedge pclk);
        rdc(`FCS_IDX_SEC, 32'hff, {24'h0, sec[7:2], 2'b10}, "unlock");
        boot(8'($urandom), 1'b1);
        rdc(`FCS_IDX_SEC, 32'hff, 32'hff, "double fault load");
        lvl(2, 1'b0, "backdoor after fault");
        apb(1'b0, 4'hd, 32'h0);
        chk(serr, 1'b1, "unmapped");
        s = n_start;
        launch(`FCS_C_PGM);
        rdc(`FCS_IDX_STAT, 32'hb0, 32'ha0, "no divider");
        launch(`FCS_C_ERSSEC);
        acc_err(32'ha0, "launch over error");
        chk(n_start, s, "refused starts");
        wr(`FCS_IDX_CLKDIV, 32'($urandom));
        do c = 8'($urandom); while (valid_code(c));
        launch(c);
        acc_err(32'ha0, "bad code");
        launch(`FCS_C_FMARGIN);
        acc_err(32'ha0, "field margin normal mode");
        wr(`FCS_IDX_PROT, 32'h1f & ~(32'h1 << ($urandom % 5)));
        launch(`FCS_C_ERSALL);
        acc_err(32'h90, "erase all protected");
        wr(`FCS_IDX_PROT, {27'h0, `FCS_PROT_ALL});
        special_mode <= 1'b1;
        foreach (codes[i]) begin
            s = n_start;
            launch(codes[i]);
            rdc(`FCS_IDX_STAT, 32'hb0, 32'h0, "busy");
            chk(n_start, s + 1, "start");
            chk(algo_cmd, codes[i], "code");
            rdc(`FCS_IDX_CMD, 32'hff, codes[i], "last code");
            if (codes[i] == `FCS_C_PGM) begin
                a = 23'($urandom);
                s = n_inv;
                rdpulse(1'b0, 1'b1, a);
                rdpulse(1'b0, 1'b1, ~a);
                chk(n_inv, s + 2, "invalid reads");
                rdc(`FCS_IDX_ERRSTAT, 32'h3, 32'h3, "fault flags");
                rdc(`FCS_IDX_ECCADR, 32'h7fffff, {9'h0, a}, "capture");
                wr(`FCS_IDX_ERRCFG, 32'h2);
                lvl(1, 1'b1, "double fault irq");
                wr(`FCS_IDX_ERRCFG, 32'h0);
                wr(`FCS_IDX_ERRSTAT, 32'h3);
            end
            done_pulse();
            rdc(`FCS_IDX_STAT, 32'hb0, 32'h80, "done");
        end
        special_mode <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            p = (k == 0) ? 7 : $urandom % 8;
            d = {$urandom, $urandom};
            {e, db} = (k < 2) ? 2'(k + 1) : 2'($urandom);
            ro(16'(p), 3'h1);
            rdc(`FCS_IDX_STAT, 32'h80, 32'h0, "read once busy");
            s = n_inv;
            rdpulse(1'b1, 1'b0, 23'($urandom));
            chk(n_inv, s + 1, "block zero read");
            nvm_ans(d, e, db, RO_BASE + 23'(8 * p));
            rdc(`FCS_IDX_STAT, 32'h83, {24'h0, 6'h20, e | db, db}, "ro");
            for (int w = 0; w < 4; w++) begin
                wr(`FCS_IDX_PIDX, 32'(w + 2));
                rdc(`FCS_IDX_PDATA, 32'hffff, d[63 - 16 * w -: 16], "w");
            end
        end
        ro(16'h1, 3'h2);
        acc_err(32'ha0, "ro index");
        ro(16'h8, 3'h1);
        acc_err(32'ha0, "ro phrase");
        load_field_active <= 1'b1;
        ro(16'h0, 3'h1);
        acc_err(32'ha0, "ro load field");
        load_field_active <= 1'b0;
        wr(`FCS_IDX_CFG, 32'h80);
        lvl(0, 1'b1, "cmd irq");
        launch(`FCS_C_EEEQ);
        lvl(0, 1'b0, "cmd irq busy");
        done_pulse();
        lvl(0, 1'b1, "cmd irq again");
        wr(`FCS_IDX_CFG, 32'h0);
        lvl(0, 1'b0, "cmd irq masked");
        wr(`FCS_IDX_ERRSTAT, 32'h7f);
        for (int i = 0; i < 6; i++) begin
            if (i < 5) emu_err_set <= 5'h1 << i;
            else single_fault_set <= 1'b1;
            @(posedge pclk);
            emu_err_set <= 5'h0;
            single_fault_set <= 1'b0;
            @(posedge pclk);
            s = (i < 5) ? (4 << i) : 1;
            rdc(`FCS_IDX_ERRSTAT, 32'h7f, s, "error flag");
            lvl(1, 1'b0, "err irq disabled");
            wr(`FCS_IDX_ERRCFG, 32'h7f);
            lvl(1, 1'b1, "err irq");
            wr(`FCS_IDX_ERRCFG, 32'h7f & ~s);
            lvl(1, 1'b0, "err irq own enable");
            wr(`FCS_IDX_ERRCFG, 32'h7f);
            wr(`FCS_IDX_ERRSTAT, s);
            lvl(1, 1'b0, "err irq cleared");
            wr(`FCS_IDX_ERRCFG, 32'h0);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
